// ---- design/bbc_pkg.sv ----
package bbc_pkg;
	localparam int SYS_CLK_MHZ = 25;
	localparam int FAULT_TIME_US = 50;
	localparam int FAULT_CYC_INT = FAULT_TIME_US * SYS_CLK_MHZ;
	localparam int TMR_W = 11;
	localparam logic [TMR_W-1:0] FAULT_CYC = TMR_W'(FAULT_CYC_INT);
	localparam int POR_TIME_MS = 200;
	localparam int POR_CYC = POR_TIME_MS * SYS_CLK_MHZ * 1000;
	localparam int POR_W = 23;
	localparam int PCLK_W = 4;
	localparam int SMP_DIV_W = 2;
	localparam logic [SMP_DIV_W-1:0] SMP_DIV_LAST = 2'h3;
	localparam int ADDR_W = 22;
	localparam int DATA_W = 16;
	localparam logic [PCLK_W-1:0] PCLK_RST = 4'h0;
	localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_ADDR = 4'h2,
		ST_WAIT = 4'h4,
		ST_END = 4'h8
	} bbc_state_t;
endpackage : bbc_pkg

// ---- design/bbc_top.sv ----
`timescale 1ns/1ps
// Summary of operation
// (RULE_01) Address strobe low frames every transfer
// (RULE_02) Upper byte strobe qualifies high data byte
// (RULE_03) Lower byte strobe qualifies low data byte
// (RULE_04) Direction high read, low write
// (RULE_05) Slave pulls acknowledge low when done
// (RULE_06) Fault asserted after 50 us without acknowledge
// (RULE_07) Power reset low 200 ms after supply good
// (RULE_08) Power reset low again on supply drop
// (RULE_09) Power reset returns logic to start state
// (RULE_10) Processor clocks by successive halving
// (RULE_11) Master acquisition clock with even duty
// (RULE_12) One sample memory clock per channel
// (RULE_13) One convert gate per channel
// (RULE_14) Trigger enable during acquisition
// (RULE_15) Two synchronous trigger lines to timebase
// (RULE_16) Only this master drives backplane lines
// (RULE_17) Slave handles data on local bus
// (RULE_18) Request and grant held at fixed levels
// (RULE_19) Slave decodes top address bits as slot
// (RULE_20) Data bit 15 MSB, bit 0 LSB
// (RULE_21) Ack released after strobe; timer restarts
module bbc_top #(
	parameter int POR_CYCLES = bbc_pkg::POR_CYC
) (
	input wire logic CLK_SYS_I,
	input wire logic SYS_RST_I,
	input wire logic SUPPLY_OK_I,
	input wire logic CPU_REQ_I,
	input wire logic CPU_READ_I,
	input wire logic CPU_UPPER_I,
	input wire logic CPU_LOWER_I,
	input wire logic [bbc_pkg::ADDR_W-1:0] CPU_ADDR_I,
	input wire logic [bbc_pkg::DATA_W-1:0] CPU_WDATA_I,
	output logic CPU_BUSY_O,
	output logic CPU_DONE_O,
	output logic CPU_FAULT_O,
	output logic [bbc_pkg::DATA_W-1:0] CPU_RDATA_O,
	output logic ADDR_STROBE_N_O,
	output logic UPPER_BYTE_STROBE_N_O,
	output logic LOWER_BYTE_STROBE_N_O,
	output logic READ_NOT_WRITE_O,
	output logic [bbc_pkg::ADDR_W-1:0] BP_ADDR_O,
	output logic [bbc_pkg::DATA_W-1:0] BP_DATA_O,
	output logic BP_DATA_OE_O,
	input wire logic [bbc_pkg::DATA_W-1:0] BP_DATA_I,
	input wire logic XFER_ACK_N_I,
	output logic BUS_FAULT_N_O,
	output logic POWERON_RST_N_O,
	output logic [bbc_pkg::PCLK_W-1:0] PROC_CLK_O,
	output logic BUS_REQ_N_O,
	output logic BUS_GRANT_N_O,
	input wire logic ACQ_RUN_I,
	input wire logic TRIG_I,
	output logic ACQ_MASTER_CLK_O,
	output logic SAMPLE_MEM_CLK_A_O,
	output logic SAMPLE_MEM_CLK_B_O,
	output logic CONVERT_GATE_A_O,
	output logic CONVERT_GATE_B_O,
	output logic TRIG_ENABLE_O,
	output logic SYNC_TRIG_A_O,
	output logic SYNC_TRIG_B_O
);
	import bbc_pkg::*;

	logic sup_s1_ff, sup_s2_ff, ack_s1_ff, ack_s2_ff, trg_s1_ff, trg_s2_ff;
	logic [DATA_W-1:0] dat_s1_ff, dat_s2_ff;
	logic [POR_W-1:0] por_cnt_ff;
	logic por_done_ff;
	logic logic_rst;
	bbc_state_t state_ff, nxt_state;
	logic [TMR_W-1:0] tmr_ff;
	logic upper_sel_ff, lower_sel_ff;
	logic [SMP_DIV_W-1:0] smp_div_ff;
	wire por_last = (por_cnt_ff == POR_W'(POR_CYCLES - 1));
	wire take_req = (state_ff == ST_IDLE) && CPU_REQ_I;
	wire ack_seen = (state_ff == ST_WAIT) && !ack_s2_ff;
	wire tmr_last = (tmr_ff == FAULT_CYC - 11'h001);
	wire time_out = (state_ff == ST_WAIT) && ack_s2_ff && tmr_last;
	wire smp_tick = ACQ_RUN_I && (smp_div_ff == SMP_DIV_LAST);
	// Armed only as a run starts; a held trigger must not re-arm it
	wire ten_arm = ACQ_RUN_I && !CONVERT_GATE_A_O;

	// Supply, acknowledge, trigger and data pins cross into this clock through two flops
	always_ff @(posedge CLK_SYS_I) begin
		sup_s1_ff <= SUPPLY_OK_I;
		sup_s2_ff <= sup_s1_ff;
		ack_s1_ff <= XFER_ACK_N_I;
		ack_s2_ff <= ack_s1_ff;
		trg_s1_ff <= TRIG_I;
		trg_s2_ff <= trg_s1_ff;
		dat_s1_ff <= BP_DATA_I;
		dat_s2_ff <= dat_s1_ff;
	end

	// Counts from supply good; a drop restarts the whole wait
	always_ff @(posedge CLK_SYS_I) begin
		if (SYS_RST_I || !sup_s2_ff) begin // RULE_08
			por_cnt_ff <= '0;
			por_done_ff <= 1'b0;
		end else if (!por_done_ff) begin // RULE_07
			por_cnt_ff <= por_last ? por_cnt_ff : por_cnt_ff + 23'h000001;
			por_done_ff <= por_last;
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (SYS_RST_I) begin
			POWERON_RST_N_O <= 1'b0;
		end else begin
			POWERON_RST_N_O <= por_done_ff && sup_s2_ff; // RULE_07
		end
	end

	// Everything below restarts while power reset is active
	assign logic_rst = SYS_RST_I || !por_done_ff; // RULE_09

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (CPU_REQ_I) begin
					nxt_state = ST_ADDR;
				end
			end
			ST_ADDR: nxt_state = ST_WAIT;
			ST_WAIT: begin
				if (ack_seen || time_out) begin // RULE_06
					nxt_state = ST_END;
				end
			end
			ST_END: begin
				// Slave must let go before the next frame
				if (ack_s2_ff) begin // RULE_21
					nxt_state = ST_IDLE;
				end
			end
			default: nxt_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (logic_rst) begin
			state_ff <= ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Timer restarts with each frame
	always_ff @(posedge CLK_SYS_I) begin
		if (logic_rst || state_ff != ST_WAIT) begin
			tmr_ff <= '0; // RULE_21
		end else if (!tmr_last) begin
			tmr_ff <= tmr_ff + 11'h001;
		end
	end

	// Address, direction and write data latched at request
	always_ff @(posedge CLK_SYS_I) begin
		if (logic_rst) begin
			BP_ADDR_O <= '0;
			BP_DATA_O <= DATA_RST;
			READ_NOT_WRITE_O <= 1'b1;
			upper_sel_ff <= 1'b0;
			lower_sel_ff <= 1'b0;
		end else if (take_req) begin
			BP_ADDR_O <= CPU_ADDR_I;
			BP_DATA_O <= CPU_WDATA_I; // RULE_20
			READ_NOT_WRITE_O <= CPU_READ_I; // RULE_04
			upper_sel_ff <= CPU_UPPER_I;
			lower_sel_ff <= CPU_LOWER_I;
		end
	end

	// Strobes low only in the wait phase, after address settles
	always_ff @(posedge CLK_SYS_I) begin
		if (logic_rst) begin
			ADDR_STROBE_N_O <= 1'b1;
			UPPER_BYTE_STROBE_N_O <= 1'b1;
			LOWER_BYTE_STROBE_N_O <= 1'b1;
			BP_DATA_OE_O <= 1'b0;
		end else begin
			ADDR_STROBE_N_O <= nxt_state != ST_WAIT; // RULE_01
			UPPER_BYTE_STROBE_N_O <= !(nxt_state == ST_WAIT && upper_sel_ff); // RULE_02
			LOWER_BYTE_STROBE_N_O <= !(nxt_state == ST_WAIT && lower_sel_ff); // RULE_03
			BP_DATA_OE_O <= (nxt_state == ST_ADDR || nxt_state == ST_WAIT)
				&& !(take_req ? CPU_READ_I : READ_NOT_WRITE_O); // RULE_16
		end
	end

	// Fault held through the end phase, then released
	always_ff @(posedge CLK_SYS_I) begin
		if (logic_rst) begin
			BUS_FAULT_N_O <= 1'b1;
			CPU_DONE_O <= 1'b0;
			CPU_FAULT_O <= 1'b0;
			CPU_BUSY_O <= 1'b0;
			CPU_RDATA_O <= DATA_RST;
		end else begin
			if (time_out) begin
				BUS_FAULT_N_O <= 1'b0; // RULE_06
			end else if (state_ff == ST_END && ack_s2_ff) begin
				BUS_FAULT_N_O <= 1'b1;
			end
			CPU_DONE_O <= ack_seen; // RULE_05
			CPU_FAULT_O <= time_out;
			CPU_BUSY_O <= nxt_state != ST_IDLE;
			if (ack_seen && READ_NOT_WRITE_O) begin
				CPU_RDATA_O <= dat_s2_ff; // RULE_20
			end
		end
	end

	// Single master: no request, grant always held
	always_ff @(posedge CLK_SYS_I) begin
		if (SYS_RST_I) begin
			BUS_REQ_N_O <= 1'b1; // RULE_18
			BUS_GRANT_N_O <= 1'b0; // RULE_18
		end else begin
			BUS_REQ_N_O <= 1'b1;
			BUS_GRANT_N_O <= 1'b0;
		end
	end

	// Synchronous counter of halving stages; rates scale with the system clock
	always_ff @(posedge CLK_SYS_I) begin
		if (logic_rst) begin
			PROC_CLK_O <= PCLK_RST;
		end else begin
			PROC_CLK_O <= PROC_CLK_O + 4'h1; // RULE_10
		end
	end

	// Toggle every cycle keeps duty at half; fastest this clock allows
	always_ff @(posedge CLK_SYS_I) begin
		if (logic_rst) begin
			ACQ_MASTER_CLK_O <= 1'b0;
		end else begin
			ACQ_MASTER_CLK_O <= !ACQ_MASTER_CLK_O; // RULE_11
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (logic_rst || !ACQ_RUN_I) begin
			smp_div_ff <= '0;
			SAMPLE_MEM_CLK_A_O <= 1'b0;
			SAMPLE_MEM_CLK_B_O <= 1'b0;
		end else begin
			smp_div_ff <= smp_div_ff + 2'h1;
			if (smp_tick) begin
				SAMPLE_MEM_CLK_A_O <= !SAMPLE_MEM_CLK_A_O; // RULE_12
				SAMPLE_MEM_CLK_B_O <= !SAMPLE_MEM_CLK_B_O; // RULE_12
			end
		end
	end

	// Trigger enable drops once a trigger is passed on
	always_ff @(posedge CLK_SYS_I) begin
		if (logic_rst) begin
			CONVERT_GATE_A_O <= 1'b0;
			CONVERT_GATE_B_O <= 1'b0;
			TRIG_ENABLE_O <= 1'b0;
			SYNC_TRIG_A_O <= 1'b0;
			SYNC_TRIG_B_O <= 1'b0;
		end else begin
			CONVERT_GATE_A_O <= ACQ_RUN_I; // RULE_13
			CONVERT_GATE_B_O <= ACQ_RUN_I; // RULE_13
			TRIG_ENABLE_O <= ACQ_RUN_I && (ten_arm || (TRIG_ENABLE_O && !trg_s2_ff)); // RULE_14
			SYNC_TRIG_A_O <= TRIG_ENABLE_O && trg_s2_ff; // RULE_15
			SYNC_TRIG_B_O <= TRIG_ENABLE_O && trg_s2_ff; // RULE_15
		end
	end

	a_strobe_frame: assert property (@(posedge CLK_SYS_I) disable iff (logic_rst) // RULE_01
		(!UPPER_BYTE_STROBE_N_O || !LOWER_BYTE_STROBE_N_O) |-> !ADDR_STROBE_N_O)
		else $error("byte strobe outside address strobe");
	a_upper_lane: assert property (@(posedge CLK_SYS_I) disable iff (logic_rst) // RULE_02
		$fell(ADDR_STROBE_N_O) |-> (UPPER_BYTE_STROBE_N_O == !upper_sel_ff))
		else $error("upper strobe does not match request");
	a_lower_lane: assert property (@(posedge CLK_SYS_I) disable iff (logic_rst) // RULE_03
		$fell(ADDR_STROBE_N_O) |-> (LOWER_BYTE_STROBE_N_O == !lower_sel_ff))
		else $error("lower strobe does not match request");
	a_dir_drive: assert property (@(posedge CLK_SYS_I) disable iff (logic_rst) // RULE_04
		!ADDR_STROBE_N_O |-> (BP_DATA_OE_O == !READ_NOT_WRITE_O))
		else $error("data drive disagrees with direction");
	a_fault_time: assert property (@(posedge CLK_SYS_I) disable iff (logic_rst) // RULE_06
		$fell(BUS_FAULT_N_O) |-> $past(tmr_ff) == FAULT_CYC - 11'h001)
		else $error("bus fault at wrong time");
	a_fault_due: assert property (@(posedge CLK_SYS_I) disable iff (logic_rst) // RULE_06
		(state_ff == ST_WAIT && ack_s2_ff && tmr_last) |=> !BUS_FAULT_N_O && CPU_FAULT_O)
		else $error("bus fault missing after timeout");
	a_por_drop: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I) // RULE_08
		!sup_s2_ff |=> !POWERON_RST_N_O ##1 !POWERON_RST_N_O)
		else $error("power reset not low on supply drop");
	a_por_hold: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I) // RULE_07
		$rose(POWERON_RST_N_O) |-> $past(por_cnt_ff, 2) == POR_W'(POR_CYCLES - 1))
		else $error("power reset released early");
	a_reset_idle: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I) // RULE_09
		!por_done_ff |=> state_ff == ST_IDLE && ADDR_STROBE_N_O)
		else $error("bus active during power reset");
	a_clk_halve: assert property (@(posedge CLK_SYS_I) disable iff (logic_rst) // RULE_10
		$fell(PROC_CLK_O[0]) |-> $changed(PROC_CLK_O[1]))
		else $error("clock stage not halving");
	a_ack_release: assert property (@(posedge CLK_SYS_I) disable iff (logic_rst) // RULE_21
		(state_ff == ST_END && !ack_s2_ff) |=> state_ff == ST_END && ADDR_STROBE_N_O)
		else $error("new frame before acknowledge released");
endmodule : bbc_top

// ---- tb/bbc_slave_model.sv ----
`timescale 1ns/1ps
module bbc_slave_model #(
	parameter logic [3:0] SLOT = 4'h3
) (
	input wire logic clk_i,
	input wire logic as_n_i,
	input wire logic uds_n_i,
	input wire logic lds_n_i,
	input wire logic rnw_i,
	input wire logic [21:0] addr_i,
	input wire logic [15:0] data_i,
	input wire logic [7:0] dly_i,
	output logic ack_n_o,
	output logic [15:0] data_o
);
	logic [15:0] mem_ff [16];
	logic [7:0] cnt_ff;
	logic sel;
	// Other slots stay silent, so the master's timer must end the cycle
	assign sel = !as_n_i && addr_i[21:18] == SLOT;
	initial begin
		ack_n_o = 1'b1;
		data_o = 16'hFFFF;
		cnt_ff = 8'h00;
		foreach (mem_ff[i]) mem_ff[i] = 16'h0000;
	end
	always @(posedge clk_i) begin
		if (!sel) begin
			// Released lines float to the pull-ups
			ack_n_o <= 1'b1;
			data_o <= 16'hFFFF;
			cnt_ff <= 8'h00;
		end else if (cnt_ff == dly_i) begin
			ack_n_o <= 1'b0;
			cnt_ff <= cnt_ff + 8'h01;
			if (rnw_i) begin
				data_o <= mem_ff[addr_i[3:0]];
			end else begin
				if (!uds_n_i) mem_ff[addr_i[3:0]][15:8] <= data_i[15:8];
				if (!lds_n_i) mem_ff[addr_i[3:0]][7:0] <= data_i[7:0];
			end
		end else if (ack_n_o) begin
			cnt_ff <= cnt_ff + 8'h01;
		end
	end
endmodule : bbc_slave_model

// ---- tb/backplane_bus_cycle_control_bench.sv ----
`timescale 1ns/1ps
module backplane_bus_cycle_control_bench;
	import bbc_pkg::*;
	typedef struct packed {
		logic r; logic u; logic l; logic [ADDR_W-1:0] a; logic [DATA_W-1:0] d; logic [DATA_W-1:0] e;
	} bbc_row_t;
	localparam logic [ADDR_W-1:0] ADR = {4'h3, 18'h00010};
	logic clk_sys = 1'b0, rst = 1'b1, sup = 1'b1, req = 1'b0, rd = 1'b0, up = 1'b0, lo = 1'b0;
	logic run = 1'b0, trg = 1'b0, seen, busy, done, flt, as_n, uds_n, lds_n, rnw, oe, ack_n, bf_n;
	logic por_n, mclk, ma, mb, ga, gb, ten, sa, sb, brq, bgr;
	logic [ADDR_W-1:0] adr = '0, bpa;
	logic [DATA_W-1:0] wd = '0, rdat, bpo, sdat, bpi;
	logic [PCLK_W-1:0] pclk, pp;
	logic [7:0] dly = 8'h02;
	bbc_row_t rows [6];
	int err_count = 0, cmp_count = 0, cyc = 0, n, k;
	always #20 clk_sys = ~clk_sys;
	assign bpi = oe ? bpo : sdat;
	bbc_top #(.POR_CYCLES(20)) bbc_top_i (
		.CLK_SYS_I(clk_sys), .SYS_RST_I(rst), .SUPPLY_OK_I(sup), .CPU_REQ_I(req),
		.CPU_READ_I(rd), .CPU_UPPER_I(up), .CPU_LOWER_I(lo), .CPU_ADDR_I(adr),
		.CPU_WDATA_I(wd), .CPU_BUSY_O(busy), .CPU_DONE_O(done), .CPU_FAULT_O(flt),
		.CPU_RDATA_O(rdat), .ADDR_STROBE_N_O(as_n), .UPPER_BYTE_STROBE_N_O(uds_n),
		.LOWER_BYTE_STROBE_N_O(lds_n), .READ_NOT_WRITE_O(rnw), .BP_ADDR_O(bpa),
		.BP_DATA_O(bpo), .BP_DATA_OE_O(oe), .BP_DATA_I(bpi), .XFER_ACK_N_I(ack_n),
		.BUS_FAULT_N_O(bf_n), .POWERON_RST_N_O(por_n), .PROC_CLK_O(pclk), .BUS_REQ_N_O(brq),
		.BUS_GRANT_N_O(bgr), .ACQ_RUN_I(run), .TRIG_I(trg), .ACQ_MASTER_CLK_O(mclk),
		.SAMPLE_MEM_CLK_A_O(ma), .SAMPLE_MEM_CLK_B_O(mb), .CONVERT_GATE_A_O(ga),
		.CONVERT_GATE_B_O(gb), .TRIG_ENABLE_O(ten), .SYNC_TRIG_A_O(sa), .SYNC_TRIG_B_O(sb)
	);
	bbc_slave_model bbc_slave_model_i (
		.clk_i(clk_sys), .as_n_i(as_n), .uds_n_i(uds_n), .lds_n_i(lds_n), .rnw_i(rnw),
		.addr_i(bpa), .data_i(bpo), .dly_i(dly), .ack_n_o(ack_n), .data_o(sdat)
	);
	task complete_run;
		if (err_count == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : complete_run
	task chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			$display("unexpected at %0t: saw %h, wanted %h", $time, s, e);
			err_count++;
		end
	endtask : chk
	task wait_por;
		n = 0;
		while (!por_n && n < 100) begin
			@(negedge clk_sys);
			n++;
		end
	endtask : wait_por
	// Lane and direction lines are checked on every strobed cycle, not just once
	task run_cycle(input bbc_row_t w);
		n = 0;
		while (busy && n < 100) begin
			@(negedge clk_sys);
			n++;
		end
		@(negedge clk_sys);
		{req, rd, up, lo, adr, wd} = {1'b1, w.r, w.u, w.l, w.a, w.d};
		@(negedge clk_sys);
		req = 1'b0;
		seen = 1'b0;
		n = 0;
		while (!done && !flt && n < 2000) begin
			if (!as_n) begin
				seen = 1'b1;
				chk(uds_n, !w.u);
				chk(lds_n, !w.l);
				chk(rnw, w.r);
				chk(bpa, w.a);
				chk(oe, !w.r);
				if (!w.r) chk(bpo, w.d);
			end
			@(negedge clk_sys);
			n++;
		end
	endtask : run_cycle
	// Ceiling well above the roughly 1500 cycles the run needs
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			err_count++;
			complete_run;
		end
	end
	initial begin
		rows = '{'{1'b0, 1'b1, 1'b1, ADR, 16'hA5C3, 16'h0000},
			'{1'b1, 1'b1, 1'b1, ADR, 16'h0000, 16'hA5C3},
			'{1'b0, 1'b1, 1'b0, ADR, 16'h12FF, 16'h0000},
			'{1'b1, 1'b1, 1'b1, ADR, 16'h0000, 16'h12C3},
			'{1'b0, 1'b0, 1'b1, ADR + 22'h1, 16'h8877, 16'h0000},
			'{1'b1, 1'b1, 1'b1, ADR + 22'h1, 16'h0000, 16'h0077}};
		repeat (9) @(negedge clk_sys);
		chk(as_n, 1);
		chk(por_n, 0);
		chk(brq, 1);
		chk(bgr, 0);
		chk(oe, 0);
		@(negedge clk_sys);
		rst = 1'b0;
		wait_por;
		chk(n >= 20 && n < 30, 1);
		foreach (rows[i]) begin
			run_cycle(rows[i]);
			chk(seen, 1);
			chk(done, 1);
			if (rows[i].r) chk(rdat, rows[i].e);
		end
		dly = 8'd60;
		run_cycle(rows[3]);
		chk({done, flt, rdat}, {2'b10, 16'h12C3});
		run_cycle(bbc_row_t'{1'b0, 1'b1, 1'b1, {4'h5, 18'h00000}, 16'h0000, 16'h0000});
		chk(flt, 1);
		chk(n, FAULT_CYC_INT + 1);
		chk(bf_n, 0);
		for (k = 0; k < 8; k++) begin
			pp = pclk;
			seen = mclk;
			@(negedge clk_sys);
			chk(pclk, PCLK_W'(pp + 4'h1));
			chk(mclk, !seen);
		end
		run = 1'b1;
		@(negedge clk_sys);
		chk({ga, gb}, 2'b11);
		k = 0;
		repeat (16) begin
			seen = ma;
			@(negedge clk_sys);
			k += (ma !== seen);
			chk(mb, ma);
		end
		chk(k, 4);
		chk(ten, 1);
		trg = 1'b1;
		repeat (2) @(negedge clk_sys);
		trg = 1'b0;
		seen = 1'b0;
		repeat (6) begin
			@(negedge clk_sys);
			seen |= sa;
			chk(sb, sa);
		end
		chk({seen, ten}, 2'b10);
		run = 1'b0;
		sup = 1'b0;
		repeat (3) @(negedge clk_sys);
		chk(por_n, 0);
		sup = 1'b1;
		wait_por;
		chk(n >= 20 && n < 30, 1);
		chk({as_n, busy, bf_n}, 3'b101);
		complete_run;
	end
endmodule : backplane_bus_cycle_control_bench
